// File: src/sms_spi_top.sv
// byte serial peripheral, master or slave, with ahb-lite registers
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sms_spi_top
	import sms_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// serial pins, oe low means driven
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOeN,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOeN,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOeN,
	input wire logic selectInN,
	// status
	output logic pinsAltEn,
	output logic irq
);
	logic [1:0] rstSync_q;
	logic rstN;
	sms_bus_e busSt_q, busSt_d;
	logic [1:0] regSel_q, regSel_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic done_q, done_d, write_collision_flag_q, write_collision_flag_d, ovr_q, ovr_d, mode_fault_flag_q, mode_fault_flag_d;
	logic outDis_q, outDis_d, softSel_q, softSel_d, intSel_q, intSel_d;
	logic [7:0] shift_q, shift_d, rxBuf_q, rxBuf_d;
	logic [3:0] edgeCnt_q, edgeCnt_d;
	logic [6:0] divCnt_q, divCnt_d;
	logic sckLvl_q, sckLvl_d, sampBit_q, sampBit_d, sckPrev_q, sckPrev_d;
	logic sckPin_q, sckPin_d, statArm_q, statArm_d, modfArm_q, modfArm_d;
	sms_xfer_e xfer_q, xfer_d;
	logic accept, wrData, wrCtrl, wrStat, rdData, rdStat;
	logic isMaster, selEff, edgeEv, finish, serialIn, startMaster;
	logic [7:0] rxByte, statView;
	logic [6:0] halfCnt;

	// half sck period minus one, in cpu clocks
	function automatic logic [6:0] sms_half(input logic [2:0] sel);
		logic [7:0] d;
		d = SMS_DIV_128;
		case (sel)
			3'b100: d = SMS_DIV_4;
			3'b000: d = SMS_DIV_8;
			3'b001: d = SMS_DIV_16;
			3'b110: d = SMS_DIV_32;
			3'b010: d = SMS_DIV_64;
			3'b011: d = SMS_DIV_128;
			default: d = SMS_DIV_128;
		endcase
		return d[7:1] - 7'd1;
	endfunction
	function automatic logic [1:0] sms_decode(input logic [31:0] a);
		logic [1:0] s;
		s = 2'd0;
		if (a[1:0] == 2'b00) begin
			if (a[31:2] == SMS_IDX_DATA)
				s = 2'd1;
			else if (a[31:2] == SMS_IDX_CTRL)
				s = 2'd2;
			else if (a[31:2] == SMS_IDX_STAT)
				s = 2'd3;
		end
		return s;
	endfunction

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rstSync_q <= 2'b00;
		else
			rstSync_q <= {rstSync_q[0], 1'b1};
	end
	assign rstN = rstSync_q[1];

	// internal select / level 0 selects
	assign selEff = softSel_q ? intSel_q : selectInN;
	assign isMaster = ctrl_q[SMS_CR_MASTER];
	assign serialIn = isMaster ? misoIn : mosiIn;
	assign statView = {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0,
		outDis_q, softSel_q, intSel_q};
	assign halfCnt = sms_half({ctrl_q[SMS_CR_DIV_EN], ctrl_q[SMS_CR_RATE1],
		ctrl_q[SMS_CR_RATE0]});

	always_comb begin
		busSt_d = busSt_q;
		regSel_d = regSel_q;
		hrdata_d = hrdata_q;
		ctrl_d = ctrl_q;
		done_d = done_q;
		write_collision_flag_d = write_collision_flag_q;
		ovr_d = ovr_q;
		mode_fault_flag_d = mode_fault_flag_q;
		outDis_d = outDis_q;
		softSel_d = softSel_q;
		intSel_d = intSel_q;
		shift_d = shift_q;
		rxBuf_d = rxBuf_q;
		edgeCnt_d = edgeCnt_q;
		divCnt_d = divCnt_q;
		sckLvl_d = sckLvl_q;
		sampBit_d = sampBit_q;
		sckPrev_d = sckIn;
		statArm_d = statArm_q;
		modfArm_d = modfArm_q;
		xfer_d = xfer_q;
		edgeEv = 1'b0;
		finish = 1'b0;
		startMaster = 1'b0;
		rxByte = {shift_q[6:0], sampBit_q};
		// bus phases; reads take one wait state
		accept = hsel && hready && hreadyout && (htrans == SMS_HTRANS_NONSEQ);
		wrData = (busSt_q == BUS_WRITE) && (regSel_q == 2'd1);
		wrCtrl = (busSt_q == BUS_WRITE) && (regSel_q == 2'd2);
		wrStat = (busSt_q == BUS_WRITE) && (regSel_q == 2'd3);
		rdData = (busSt_q == BUS_READ) && (regSel_q == 2'd1);
		rdStat = (busSt_q == BUS_READ) && (regSel_q == 2'd3);
		if (busSt_q == BUS_READ) begin
			busSt_d = BUS_RDY;
			case (regSel_q)
				2'd1: hrdata_d = {24'h000000, rxBuf_q};
				2'd2: hrdata_d = {24'h000000, ctrl_q};
				2'd3: hrdata_d = {24'h000000, statView};
				default: hrdata_d = 32'h00000000;
			endcase
		end else if (accept) begin
			busSt_d = hwrite ? BUS_WRITE : BUS_READ;
			regSel_d = sms_decode(haddr);
		end else begin
			busSt_d = BUS_IDLE;
		end
		// status read clears overrun, arms clear sequences
		if (rdStat) begin
			ovr_d = 1'b0;
			statArm_d = 1'b1;
			modfArm_d = mode_fault_flag_q;
		end
		// done cleared by data access after status read
		if (statArm_q && (rdData || wrData)) begin
			done_d = 1'b0;
			statArm_d = 1'b0;
		end
		// collision cleared by the read half of the sequence
		if (statArm_q && rdData)
			write_collision_flag_d = 1'b0;
		if (wrCtrl) begin
			ctrl_d = hwdata[7:0];
			// fault clears on control write after armed status read
			if (modfArm_q) begin
				mode_fault_flag_d = 1'b0;
				modfArm_d = 1'b0;
			end else if (mode_fault_flag_q) begin
				ctrl_d[SMS_CR_PERIPH_EN] = 1'b0;
				ctrl_d[SMS_CR_MASTER] = 1'b0;
			end
		end
		if (wrStat) begin
			outDis_d = hwdata[SMS_SR_OUT_DIS];
			softSel_d = hwdata[SMS_SR_SOFT_SEL];
			intSel_d = hwdata[SMS_SR_INT_SEL];
		end
		if (wrData) begin
			if (xfer_q == XFER_BUSY) begin
				write_collision_flag_d = 1'b1;
			end else if (!done_q || statArm_q) begin
				// accepted only outside the done-flag lock
				// byte goes straight into the shifter
				shift_d = hwdata[7:0];
				if (isMaster && ctrl_q[SMS_CR_PERIPH_EN]) begin
					startMaster = 1'b1;
					xfer_d = XFER_BUSY;
					edgeCnt_d = 4'h0;
					divCnt_d = 7'd0;
					sckLvl_d = 1'b0;
				end
			end
		end
		// divider ticks only in master / slave uses sck pin
		if (isMaster) begin
			if (xfer_q == XFER_BUSY) begin
				if (divCnt_q == halfCnt) begin
					divCnt_d = 7'd0;
					edgeEv = 1'b1;
				end else begin
					divCnt_d = divCnt_q + 7'd1;
				end
			end
		end else if (ctrl_q[SMS_CR_PERIPH_EN] && !selEff) begin
			edgeEv = (sckIn != sckPrev_q);
		end else if (xfer_q == XFER_BUSY) begin
			xfer_d = XFER_IDLE;
			edgeCnt_d = 4'h0;
		end
		if (edgeEv) begin
			xfer_d = XFER_BUSY;
			edgeCnt_d = edgeCnt_q + 4'h1;
			sckLvl_d = !sckLvl_q;
			// capture edge set by clock_phase / msb first
			if (edgeCnt_q[0] == ctrl_q[SMS_CR_CLOCK_PHASE]) begin
				sampBit_d = serialIn;
				rxByte = {shift_q[6:0], serialIn};
			end else if (!(ctrl_q[SMS_CR_CLOCK_PHASE] && edgeCnt_q == 4'h0)) begin
				shift_d = rxByte;
			end
			if (edgeCnt_q == SMS_LAST_EDGE) begin
				finish = 1'b1;
				shift_d = rxByte;
			end
		end
		if (finish) begin
			xfer_d = XFER_IDLE;
			edgeCnt_d = 4'h0;
			sckLvl_d = 1'b0;
			// overrun / buffer keeps first byte
			if (done_q && done_d) begin
				ovr_d = 1'b1;
			end else begin
				// done flag set / buffer loaded at byte end
				done_d = 1'b1;
				rxBuf_d = rxByte;
			end
		end
		// select low in master mode is a fault
		if (isMaster && !selEff) begin
			mode_fault_flag_d = 1'b1;
			ctrl_d[SMS_CR_PERIPH_EN] = 1'b0;
			ctrl_d[SMS_CR_MASTER] = 1'b0;
			xfer_d = XFER_IDLE;
			edgeCnt_d = 4'h0;
			sckLvl_d = 1'b0;
		end
		sckPin_d = ctrl_d[SMS_CR_CLOCK_POLARITY] ^ sckLvl_d;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			busSt_q <= BUS_IDLE;
			regSel_q <= 2'd0;
			hrdata_q <= 32'h00000000;
			ctrl_q <= SMS_CR_RESET;
			done_q <= SMS_SR_RESET[SMS_SR_DONE];
			write_collision_flag_q <= SMS_SR_RESET[SMS_SR_WRITE_COLLISION_FLAG];
			ovr_q <= SMS_SR_RESET[SMS_SR_OVR];
			mode_fault_flag_q <= SMS_SR_RESET[SMS_SR_MODE_FAULT_FLAG];
			outDis_q <= SMS_SR_RESET[SMS_SR_OUT_DIS];
			softSel_q <= SMS_SR_RESET[SMS_SR_SOFT_SEL];
			intSel_q <= SMS_SR_RESET[SMS_SR_INT_SEL];
			shift_q <= SMS_DATA_RESET;
			rxBuf_q <= SMS_DATA_RESET;
			edgeCnt_q <= 4'h0;
			divCnt_q <= 7'd0;
			sckLvl_q <= 1'b0;
			sampBit_q <= 1'b0;
			sckPrev_q <= 1'b0;
			sckPin_q <= 1'b0;
			statArm_q <= 1'b0;
			modfArm_q <= 1'b0;
			xfer_q <= XFER_IDLE;
		end else begin
			busSt_q <= busSt_d;
			regSel_q <= regSel_d;
			hrdata_q <= hrdata_d;
			ctrl_q <= ctrl_d;
			done_q <= done_d;
			write_collision_flag_q <= write_collision_flag_d;
			ovr_q <= ovr_d;
			mode_fault_flag_q <= mode_fault_flag_d;
			outDis_q <= outDis_d;
			softSel_q <= softSel_d;
			intSel_q <= intSel_d;
			shift_q <= shift_d;
			rxBuf_q <= rxBuf_d;
			edgeCnt_q <= edgeCnt_d;
			divCnt_q <= divCnt_d;
			sckLvl_q <= sckLvl_d;
			sampBit_q <= sampBit_d;
			sckPrev_q <= sckPrev_d;
			sckPin_q <= sckPin_d;
			statArm_q <= statArm_d;
			modfArm_q <= modfArm_d;
			xfer_q <= xfer_d;
		end
	end

	assign hreadyout = (busSt_q != BUS_READ);
	assign hresp = SMS_HRESP_OKAY;
	assign hrdata = hrdata_q;
	assign pinsAltEn = ctrl_q[SMS_CR_PERIPH_EN];
	assign sckOut = sckPin_q;
	assign mosiOut = shift_q[7];
	assign misoOut = shift_q[7];
	assign sckOeN = !(pinsAltEn && isMaster);
	assign mosiOeN = !(pinsAltEn && isMaster && !outDis_q);
	assign misoOeN = !(pinsAltEn && !isMaster && !selEff && !outDis_q);
	// one request from three flags, collision excluded
	assign irq = ctrl_q[SMS_CR_IRQ_EN] && (done_q || mode_fault_flag_q || ovr_q);

	// cycles since last master sck toggle
	logic [7:0] gapCnt;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			gapCnt <= 8'h00;
		else if (xfer_q == XFER_IDLE || edgeEv)
			gapCnt <= 8'h00;
		else
			gapCnt <= gapCnt + 8'h01;
	end

	sequence s_last_edge;
		edgeEv && edgeCnt_q == SMS_LAST_EDGE;
	endsequence
	sequence s_fault;
		isMaster && !selEff;
	endsequence

	chk_irq_raise: assert property (@(posedge clk) disable iff (!rstN)
		($rose(done_q) && ctrl_q[SMS_CR_IRQ_EN]) |-> irq && !$past(irq))
		else $error("interrupt not raised with done flag");
	chk_fault_drop: assert property (@(posedge clk) disable iff (!rstN)
		s_fault |=> !ctrl_q[SMS_CR_PERIPH_EN] && !isMaster && mode_fault_flag_q)
		else $error("mode fault did not drop enable and master");
	chk_rate_gap: assert property (@(posedge clk) disable iff (!rstN)
		(isMaster && edgeEv
		&& !(ctrl_q[SMS_CR_DIV_EN] && ctrl_q[SMS_CR_RATE0]))
		|-> {gapCnt[6:0], 1'b0} + 8'h02 == (ctrl_q[SMS_CR_DIV_EN] ?
		(ctrl_q[SMS_CR_RATE1] ? SMS_DIV_32 : SMS_DIV_4) :
		ctrl_q[SMS_CR_RATE1] ?
		(ctrl_q[SMS_CR_RATE0] ? SMS_DIV_128 : SMS_DIV_64) :
		(ctrl_q[SMS_CR_RATE0] ? SMS_DIV_16 : SMS_DIV_8)))
		else $error("sck half period wrong");
	chk_idle_level: assert property (@(posedge clk) disable iff (!rstN)
		(xfer_q == XFER_IDLE) |-> sckPin_q == ctrl_q[SMS_CR_CLOCK_POLARITY])
		else $error("sck idle level differs from polarity");
	chk_done_set: assert property (@(posedge clk) disable iff (!rstN)
		s_last_edge ##0 !done_q |=> done_q && rxBuf_q == $past(rxByte))
		else $error("byte end did not set done and buffer");
	chk_lock_write: assert property (@(posedge clk) disable iff (!rstN)
		(wrData && done_q && !statArm_q && xfer_q == XFER_IDLE && !edgeEv)
		|=> $stable(shift_q) && xfer_q == XFER_IDLE)
		else $error("locked data write was taken");
	chk_write_collision_flag_set: assert property (@(posedge clk) disable iff (!rstN)
		(wrData && xfer_q == XFER_BUSY) |=> write_collision_flag_q)
		else $error("collision flag not set");
	chk_ovr_keep: assert property (@(posedge clk) disable iff (!rstN)
		(s_last_edge ##0 done_q && !statArm_q) |=> ovr_q && $stable(rxBuf_q))
		else $error("overrun not flagged or buffer overwritten");
	chk_out_release: assert property (@(posedge clk) disable iff (!rstN)
		outDis_q |-> mosiOeN && misoOeN)
		else $error("serial output driven while disabled");
	chk_byte_len: assert property (@(posedge clk) disable iff (!rstN)
		startMaster ##1 (xfer_q == XFER_BUSY && selEff)[*2] |->
		edgeCnt_q <= 4'h1)
		else $error("byte started with wrong edge count");
endmodule
`default_nettype wire

// File: src/sms_pkg.sv
// shared constants for the serial peripheral block
package sms_pkg;
	// register indices; byte address is four times the index
	localparam logic [29:0] SMS_IDX_DATA = 30'h00000021;
	localparam logic [29:0] SMS_IDX_CTRL = 30'h00000022;
	localparam logic [29:0] SMS_IDX_STAT = 30'h00000023;
	// serial_control fields
	localparam int SMS_CR_IRQ_EN = 7;
	localparam int SMS_CR_PERIPH_EN = 6;
	localparam int SMS_CR_DIV_EN = 5;
	localparam int SMS_CR_MASTER = 4;
	localparam int SMS_CR_CLOCK_POLARITY = 3;
	localparam int SMS_CR_CLOCK_PHASE = 2;
	localparam int SMS_CR_RATE1 = 1;
	localparam int SMS_CR_RATE0 = 0;
	// serial_control_status fields
	localparam int SMS_SR_DONE = 7;
	localparam int SMS_SR_WRITE_COLLISION_FLAG = 6;
	localparam int SMS_SR_OVR = 5;
	localparam int SMS_SR_MODE_FAULT_FLAG = 4;
	localparam int SMS_SR_OUT_DIS = 2;
	localparam int SMS_SR_SOFT_SEL = 1;
	localparam int SMS_SR_INT_SEL = 0;
	// reset values
	localparam logic [7:0] SMS_CR_RESET = 8'h00;
	localparam logic [7:0] SMS_SR_RESET = 8'h00;
	localparam logic [7:0] SMS_DATA_RESET = 8'h00;
	// master clock divisors of the cpu clock
	localparam logic [7:0] SMS_DIV_4 = 8'h04;
	localparam logic [7:0] SMS_DIV_8 = 8'h08;
	localparam logic [7:0] SMS_DIV_16 = 8'h10;
	localparam logic [7:0] SMS_DIV_32 = 8'h20;
	localparam logic [7:0] SMS_DIV_64 = 8'h40;
	localparam logic [7:0] SMS_DIV_128 = 8'h80;
	// sck edges in one byte, counted from zero
	localparam logic [3:0] SMS_LAST_EDGE = 4'hF;
	// ahb-lite codes
	localparam logic [1:0] SMS_HTRANS_NONSEQ = 2'h2;
	localparam logic SMS_HRESP_OKAY = 1'b0;
	typedef enum logic [0:0] {XFER_IDLE, XFER_BUSY} sms_xfer_e;
	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ, BUS_RDY} sms_bus_e;
endpackage

// File: tb/sms_far_slave.sv
// far-side serial slave model, answering the block in master mode
`timescale 1ns/1ps
`default_nettype none
module sms_far_slave (
	// serial lines
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	input wire logic selN,
	// mode and data
	input wire logic clock_polarity,
	input wire logic clock_phase,
	input wire logic [7:0] txByte,
	output logic [7:0] rxByte
);
	logic [7:0] tx = 8'h00;
	logic [2:0] idx = 3'h7;
	logic first = 1'b1;
	logic hold = 1'b0;
	// released line shows the inverse of its last bit
	assign miso = selN ? ~hold : tx[idx];
	always @(negedge selN) begin
		tx = txByte;
		idx = 3'h7;
		first = 1'b1;
	end
	always @(posedge selN) begin
		hold = tx[idx];
	end
	always @(sck) begin
		if (!selN) begin
			if ((sck != clock_polarity) ^ clock_phase)
				rxByte = {rxByte[6:0], mosi};
			else if (!first || !clock_phase)
				idx = idx - 3'h1;
			first = 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the serial peripheral block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sms_pkg::*;
	logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, selectInN = 1;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0] htrans = 0;
	logic farSelN = 1, clock_polarity = 0, clock_phase = 0, rdDph = 0;
	logic slvMode = 0, slvSck = 0, slvMosi = 0;
	logic [7:0] b1, b2;
	logic [7:0] farTx = 0, lastRd, e, m;
	logic [31:0] seed = 32'h0000FBA7;
	int failCount = 0, checksDone = 0;
	logic [7:0] expQ[$], mskQ[$];
	wire logic hreadyout, hresp, sckOut, sckOeN, mosiOut, mosiOeN, farMiso;
	wire logic misoOut, misoOeN, pinsAltEn, irq;
	wire logic [31:0] hrdata;
	wire logic [7:0] farRx;
	wire logic sckW = sckOeN ? (slvMode ? slvSck : clock_polarity) : sckOut;
	wire logic mosiW = mosiOeN ? (slvMode ? slvMosi : ~mosiOut) : mosiOut;
	logic [7:0] rateCfg [6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};
	logic [7:0] divs [6] = '{SMS_DIV_4, SMS_DIV_8, SMS_DIV_16, SMS_DIV_32,
		SMS_DIV_64, SMS_DIV_128};
	always #5 clk = ~clk;
	sms_spi_top u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .sckIn(sckW), .sckOut(sckOut), .sckOeN(sckOeN),
		.mosiIn(mosiW), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
		.misoIn(farMiso), .misoOut(misoOut), .misoOeN(misoOeN),
		.selectInN(selectInN), .pinsAltEn(pinsAltEn), .irq(irq));
	sms_far_slave u_far (.sck(sckW), .mosi(mosiW), .miso(farMiso),
		.selN(farSelN), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .txByte(farTx),
		.rxByte(farRx));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [7:0] got, exp, mask);
		checksDone++;
		if ((got & mask) !== (exp & mask)) begin
			failCount++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [29:0] i,
		input logic [7:0] d, ex, mk);
		hsel <= 1'b1;
		haddr <= {i, 2'b00};
		hwrite <= w;
		htrans <= SMS_HTRANS_NONSEQ;
		if (!w) begin
			expQ.push_back(ex);
			mskQ.push_back(mk);
		end
		@(negedge clk);
		while (!hreadyout) @(negedge clk);
		@(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		@(negedge clk);
		while (!hreadyout) @(negedge clk);
		lastRd = hrdata[7:0];
		@(posedge clk);
	endtask
	task automatic wr(input logic [29:0] i, input logic [7:0] d);
		bus(1'b1, i, d, 8'h00, 8'h00);
	endtask
	task automatic rd(input logic [29:0] i, input logic [7:0] ex, mk);
		bus(1'b0, i, 8'h00, ex, mk);
	endtask
	// read results checked in order of issue
	always @(negedge clk) begin
		if (rdDph && hreadyout) begin
			m = mskQ.pop_front();
			e = expQ.pop_front();
			if (m != 8'h00) chk(hrdata[7:0], e, m);
		end
		if (hsel && htrans == SMS_HTRANS_NONSEQ && !hwrite && hreadyout)
			rdDph = 1'b1;
		else if (hreadyout)
			rdDph = 1'b0;
	end
	// far master: one byte, clock_polarity 0 clock_phase 0, msb first
	task automatic sByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			slvMosi <= b[i];
			repeat (2) @(posedge clk);
			slvSck <= 1'b1;
			repeat (2) @(posedge clk);
			slvSck <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic xfer(input int k, input logic coll);
		logic [7:0] d, cfg;
		logic p;
		int n;
		d = rnd();
		farTx = rnd();
		cfg = rateCfg[k] | 8'h90 | (rnd() & 8'h0C);
		clock_polarity = cfg[3];
		clock_phase = cfg[2];
		wr(SMS_IDX_CTRL, cfg); // disabled while polarity changes
		wr(SMS_IDX_CTRL, cfg | 8'h40);
		@(negedge clk);
		chk(8'(sckW), 8'(clock_polarity), 8'h01);
		chk(8'(sckOeN), 8'h00, 8'h01);
		@(posedge clk);
		farSelN <= 1'b0;
		wr(SMS_IDX_DATA, d);
		if (coll) wr(SMS_IDX_DATA, ~d);
		@(negedge clk);
		p = sckOut;
		while (sckOut === p) @(negedge clk);
		p = sckOut;
		n = 0;
		while (sckOut === p) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n), divs[k] >> 1, 8'hFF);
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk(8'(irq), 8'h01, 8'h01);
		@(posedge clk);
		farSelN <= 1'b1;
		rd(SMS_IDX_STAT, {1'b1, coll, 6'h0}, 8'hF0);
		rd(SMS_IDX_DATA, farTx, 8'hFF);
		rd(SMS_IDX_STAT, 8'h00, 8'hF0);
		chk(8'(irq), 8'h00, 8'h01);
		chk(farRx, d, 8'hFF);
		wr(SMS_IDX_CTRL, cfg);
		$display("transfer test %0d done", k);
	endtask
	task automatic testDone();
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		failCount++;
		testDone();
	end
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rd(SMS_IDX_CTRL, 8'h00, 8'hF0);
		wr(SMS_IDX_STAT, 8'h08);
		rd(SMS_IDX_STAT, 8'h00, 8'hFF);
		wr(30'h24, 8'hFF);
		rd(30'h24, 8'h00, 8'hFF);
		$display("register test done");
		for (int k = 0; k < 6; k++) xfer(k, k == 0);
		wr(SMS_IDX_CTRL, 8'hD0);
		wr(SMS_IDX_STAT, 8'h07);
		selectInN <= 1'b0;
		rd(SMS_IDX_STAT, 8'h07, 8'hFF);
		wr(SMS_IDX_STAT, 8'h06);
		rd(SMS_IDX_STAT, 8'h16, 8'hFF);
		chk(8'(irq), 8'h01, 8'h01);
		rd(SMS_IDX_CTRL, 8'h80, 8'hFF);
		chk(8'(pinsAltEn), 8'h00, 8'h01);
		wr(SMS_IDX_CTRL, 8'h00);
		rd(SMS_IDX_STAT, 8'h06, 8'hFF);
		selectInN <= 1'b1;
		wr(SMS_IDX_STAT, 8'h00);
		$display("mode fault test done");
		wr(SMS_IDX_CTRL, 8'h50);
		wr(SMS_IDX_STAT, 8'h04);
		@(negedge clk);
		chk(8'(mosiOeN), 8'h01, 8'h01);
		@(posedge clk);
		wr(SMS_IDX_STAT, 8'h00);
		@(negedge clk);
		chk(8'(mosiOeN), 8'h00, 8'h01);
		chk(8'(misoOeN), 8'h01, 8'h01);
		@(posedge clk);
		wr(SMS_IDX_CTRL, 8'h00);
		$display("output disable test done");
		slvMode <= 1'b1;
		wr(SMS_IDX_CTRL, 8'h63);
		wr(SMS_IDX_STAT, 8'h02);
		b1 = rnd();
		b2 = rnd();
		sByte(b1);
		sByte(b2);
		rd(SMS_IDX_STAT, 8'hA2, 8'hFF);
		rd(SMS_IDX_DATA, b1, 8'hFF);
		rd(SMS_IDX_STAT, 8'h02, 8'hFF);
		wr(SMS_IDX_CTRL, 8'h00);
		wr(SMS_IDX_STAT, 8'h00);
		slvMode <= 1'b0;
		$display("slave overrun test done");
		repeat (3) @(posedge clk);
		testDone();
	end
endmodule
`default_nettype wire
